// *** hw/tabp_pkg.sv ***
// Package for the shared transmit add-bus pin block: modes, timing, widths.
// Assumes a 125 MHz core clock; all link clocks are sampled by it.
package tabp_pkg;
  // Operating modes when the add bus is disabled
  typedef enum logic [3:0] {
    TABP_MODE_HDLC   = 4'b0001,
    TABP_MODE_MAPPER = 4'b0010,
    TABP_MODE_CLEAR  = 4'b0100,
    TABP_MODE_OTHER  = 4'b1000
  } tabp_mode_t;

  // Signal type carried on the slow port
  typedef enum logic [1:0] {
    TABP_SIG_E3  = 2'h0,
    TABP_SIG_DS3 = 2'h1,
    TABP_SIG_STS = 2'h2
  } tabp_sig_t;

  localparam int unsigned CLK_KHZ        = 125000;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned SYNC_STAGES    = 3;
  // Slow port output clock half periods in core cycles (core clock limits accuracy)
  localparam int unsigned SLOW_E3_KHZ    = 34368;
  localparam int unsigned SLOW_DS3_KHZ   = 44736;
  localparam int unsigned SLOW_STS_KHZ   = 51840;
  localparam logic [3:0]  HALF_E3        = 4'(CLK_KHZ / (2 * SLOW_E3_KHZ));
  localparam logic [3:0]  HALF_DS3       = 4'(CLK_KHZ / (2 * SLOW_DS3_KHZ));
  localparam logic [3:0]  HALF_STS       = 4'(CLK_KHZ / (2 * SLOW_STS_KHZ));
  // HDLC byte clock half period in core cycles
  localparam logic [3:0]  HDLC_HALF      = 4'h4;
  // Payload frame length in bits and overhead spacing
  localparam logic [15:0] FRAME_BITS_DEF = 16'h1_0A0;
  localparam logic [7:0]  OH_SPACING_DEF = 8'h55;
  localparam logic [3:0]  HALF_ZERO      = 4'h0;
endpackage

// *** hw/tabp_sync.sv ***
// Three-stage pin synchroniser with agreement check and edge detect.
// Assumes inputs are asynchronous to clk_in.
module tabp_sync
  import tabp_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          arst_n_in,
  // Raw pins
  input  wire logic [W-1:0]  pins_in,
  // Clean levels and edges
  tabp_sync_if.src           sync_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;

  // Stage one feeds stage two only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pins_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level changes only when stages two and three agree, filtering glitches
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lvl_ff <= '0;
    end else begin
      lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
    end
  end

  assign sync_out.level = lvl_ff;
  assign sync_out.rise  = (s2_ff & s3_ff) & ~lvl_ff;
  assign sync_out.fall  = ~(s2_ff | s3_ff) & lvl_ff;
endmodule

// *** hw/tabp_sync_if.sv ***
// Interface carrying synchronised pin levels and their edges to the top.
// Assumes both ends run on the core clock.
interface tabp_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// *** hw/tabp_top.sv ***
// Shared transmit pins bits 3..5: add bus, HDLC byte bus, slow port clock,
// payload overhead indicator and frame boundary.
// Assumes link clocks are far slower than clk_in and sampled by it.
module tabp_top
  import tabp_pkg::*;
#(
  parameter logic [15:0] FRAME_BITS = FRAME_BITS_DEF,
  parameter logic [7:0]  OH_SPACING = OH_SPACING_DEF
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  // Configuration
  input  wire logic               add_bus_enable_in,
  input  wire tabp_mode_t         mode_in,
  input  wire logic               slow_port_is_input_in,
  input  wire tabp_sig_t          slow_sig_type_in,
  // Add bus and HDLC byte bits other than the shared ones
  input  wire logic [BYTE_W-1:0]  bus_other_in,
  input  wire logic               add_bus_clock_in,
  // Shared pins 3,4,5
  input  wire logic [2:0]         shared_pin_in,
  output logic [2:0]              shared_pin_out,
  output logic [2:0]              shared_pin_oe_n_out,
  // HDLC byte clock
  output logic                    hdlc_tx_byte_clock_out,
  // Payload serial path
  input  wire logic               payload_serial_in,
  input  wire logic               payload_input_clock_in,
  // Slow port drop data (mapper output mode)
  input  wire logic               drop_bit_in,
  output logic                    slow_data_out,
  // Captured results
  output logic [BYTE_W-1:0]       add_byte_out,
  output logic                    add_byte_valid_out,
  output logic [BYTE_W-1:0]       hdlc_byte_out,
  output logic                    hdlc_byte_valid_out,
  output logic                    slow_add_bit_out,
  output logic                    slow_add_valid_out,
  output logic                    payload_bit_out,
  output logic                    payload_valid_out
);
  localparam int unsigned NSYNC = 3;

  tabp_sync_if #(.W(NSYNC)) clk_sync ();
  tabp_sync_if #(.W(1))     dat_sync ();
  logic [BYTE_W-1:0] byte_raw;

  // Clocks through the agreement synchroniser; payload data alongside
  tabp_sync #(.W(NSYNC)) u_clk_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .pins_in   ({payload_input_clock_in, shared_pin_in[0], add_bus_clock_in}),
    .sync_out  (clk_sync)
  );
  tabp_sync #(.W(1)) u_dat_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .pins_in   (payload_serial_in),
    .sync_out  (dat_sync)
  );

  // Role decode: add bus wins over every configured mode
  logic role_add;
  logic role_hdlc;
  logic role_map;
  logic role_clear;
  assign role_add   = add_bus_enable_in;
  assign role_hdlc  = !add_bus_enable_in && (mode_in == TABP_MODE_HDLC);
  assign role_map   = !add_bus_enable_in && (mode_in == TABP_MODE_MAPPER);
  assign role_clear = !add_bus_enable_in && (mode_in == TABP_MODE_CLEAR);

  // Byte assembly: shared pins land in bits 3..5, bit 0 is the LSB
  always_comb begin
    byte_raw      = bus_other_in;
    byte_raw[5:3] = shared_pin_in;
  end

  // Add bus capture on falling add bus clock
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      add_byte_out       <= '0;
      add_byte_valid_out <= 1'b0;
    end else begin
      add_byte_valid_out <= role_add && clk_sync.fall[0];
      if (role_add && clk_sync.fall[0]) begin
        add_byte_out <= byte_raw;
      end
    end
  end

  // HDLC byte clock generator and rising edge capture
  logic [3:0] hdlc_cnt_ff;
  logic       hdlc_clk_ff;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hdlc_cnt_ff <= HALF_ZERO;
      hdlc_clk_ff <= 1'b0;
    end else if (!role_hdlc) begin
      hdlc_cnt_ff <= HALF_ZERO;
      hdlc_clk_ff <= 1'b0;
    end else if (hdlc_cnt_ff == HDLC_HALF - 4'h1) begin
      hdlc_cnt_ff <= HALF_ZERO;
      hdlc_clk_ff <= !hdlc_clk_ff;
    end else begin
      hdlc_cnt_ff <= hdlc_cnt_ff + 4'h1;
    end
  end
  assign hdlc_tx_byte_clock_out = hdlc_clk_ff;

  // Sample at the internal rising edge; pins have had a half period to settle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hdlc_byte_out       <= '0;
      hdlc_byte_valid_out <= 1'b0;
    end else begin
      hdlc_byte_valid_out <= 1'b0;
      if (role_hdlc && !hdlc_clk_ff && hdlc_cnt_ff == HDLC_HALF - 4'h1) begin
        hdlc_byte_out       <= byte_raw;
        hdlc_byte_valid_out <= 1'b1;
      end
    end
  end

  // Slow port: output mode divides the core clock, input mode samples
  logic [3:0] slow_half;
  logic [3:0] slow_cnt_ff;
  logic       slow_clk_ff;
  logic       slow_drive;
  always_comb begin
    unique case (slow_sig_type_in)
      TABP_SIG_DS3: slow_half = HALF_DS3;
      TABP_SIG_STS: slow_half = HALF_STS;
      default:      slow_half = HALF_E3;
    endcase
  end
  assign slow_drive = role_map && !slow_port_is_input_in;

  // Rates are approximated by integer division of the core clock
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slow_cnt_ff <= HALF_ZERO;
      slow_clk_ff <= 1'b0;
    end else if (!slow_drive) begin
      slow_cnt_ff <= HALF_ZERO;
      slow_clk_ff <= 1'b0;
    end else if (slow_cnt_ff >= slow_half - 4'h1) begin
      slow_cnt_ff <= HALF_ZERO;
      slow_clk_ff <= !slow_clk_ff;
    end else begin
      slow_cnt_ff <= slow_cnt_ff + 4'h1;
    end
  end

  // Drop data updates on the falling slow clock; add data taken on rising
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slow_data_out      <= 1'b0;
      slow_add_bit_out   <= 1'b0;
      slow_add_valid_out <= 1'b0;
    end else begin
      slow_add_valid_out <= 1'b0;
      if (slow_drive && slow_clk_ff && slow_cnt_ff >= slow_half - 4'h1) begin
        slow_data_out <= drop_bit_in;
      end
      // External clock at the signal rate is assumed present
      if (role_map && slow_port_is_input_in && clk_sync.rise[1]) begin
        slow_add_bit_out   <= bus_other_in[0];
        slow_add_valid_out <= 1'b1;
      end
    end
  end

  // Payload position counters, stepped on each payload clock rise
  logic [15:0] bit_pos_ff;
  logic [7:0]  oh_cnt_ff;
  logic        oh_now_ff;
  logic        oh_next;
  logic        fp_ff;
  logic        pay_rise;
  assign pay_rise = role_clear && clk_sync.rise[2];
  assign oh_next  = (oh_cnt_ff == OH_SPACING - 8'h1) ||
                    (bit_pos_ff == FRAME_BITS - 16'h1);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_pos_ff <= '0;
      oh_cnt_ff  <= '0;
      oh_now_ff  <= 1'b0;
      fp_ff      <= 1'b0;
    end else if (!role_clear) begin
      bit_pos_ff <= '0;
      oh_cnt_ff  <= '0;
      oh_now_ff  <= 1'b0;
      // Role entry starts a frame, so its first bit is marked too
      fp_ff      <= 1'b1;
    end else if (pay_rise) begin
      bit_pos_ff <= (bit_pos_ff == FRAME_BITS - 16'h1) ? 16'h0 : bit_pos_ff + 16'h1;
      oh_cnt_ff  <= oh_next ? 8'h0 : oh_cnt_ff + 8'h1;
      oh_now_ff  <= oh_next;
      fp_ff      <= (bit_pos_ff == FRAME_BITS - 16'h1);
    end
  end

  // Payload capture on rise; overhead positions are dropped
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      payload_bit_out   <= 1'b0;
      payload_valid_out <= 1'b0;
    end else begin
      payload_valid_out <= pay_rise && !oh_now_ff;
      if (pay_rise && !oh_now_ff) begin
        payload_bit_out <= dat_sync.level;
      end
    end
  end

  // Pin drivers; enables are active low
  always_comb begin
    shared_pin_out      = 3'h0;
    shared_pin_oe_n_out = 3'h7;
    if (slow_drive) begin
      shared_pin_out[0]      = slow_clk_ff;
      shared_pin_oe_n_out[0] = 1'b0;
    end
    if (role_clear) begin
      shared_pin_out[1]      = oh_next;
      shared_pin_out[2]      = fp_ff;
      shared_pin_oe_n_out[2:1] = 2'h0;
    end
  end
endmodule

// *** verification/tabp_far_end.sv ***
// Far-end payload source for clear-channel mode.
// Assumes the core clock and a role enable from the bench.
module tabp_far_end (
  // Clock, enable, indicator pin
  input  wire logic clk_in,
  input  wire logic en_in,
  input  wire logic oh_in,
  // Payload clock and data
  output logic      pclk_out,
  output logic      pdat_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  int k;
  logic hold;
  function automatic logic pbit(int n);
    return ^(n & 32'h0000_005b);
  endfunction
  initial begin
    ph = 0;
    k = 0;
    hold = 1'b0;
    pclk_out = 1'b0;
    pdat_out = 1'b0;
  end
  // Idle: clock stands low, data line wanders so stale bits never match
  always @(negedge clk_in) begin
    if (!en_in) begin
      ph <= 0;
      hold <= 1'b0;
      pclk_out <= 1'b0;
      pdat_out <= ~pdat_out;
    end else begin
      ph <= (ph == 19) ? 0 : ph + 1;
      pclk_out <= (ph >= 9 && ph < 19); // Rises at phase 9
      // Indicator taken at the clock rise, before the design steps on
      if (ph == 9) begin
        hold <= oh_in;
      end
      if (ph == 0) begin
        pdat_out <= hold ? ~pbit(k) : pbit(k);
        k <= hold ? k : k + 1;
      end
    end
  end
endmodule

// *** verification/tabp_sva.sv ***
// Checker for the shared pins: role choice, pin direction, clocks.
// Assumes a bind into tabp_top; sees its ports only.
module tabp_sva
  import tabp_pkg::*;
#(
  parameter logic [15:0] FRAME_BITS = FRAME_BITS_DEF,
  parameter logic [7:0]  OH_SPACING = OH_SPACING_DEF
) (
  // Clock, reset, configuration
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       add_bus_enable_in,
  input wire tabp_mode_t mode_in,
  input wire logic       slow_port_is_input_in,
  // Watched outputs
  input wire logic [2:0] shared_pin_out,
  input wire logic [2:0] shared_pin_oe_n_out,
  input wire logic       hdlc_tx_byte_clock_out,
  input wire logic       add_byte_valid_out,
  input wire logic       hdlc_byte_valid_out,
  input wire logic       payload_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Role decode; the add bus wins over the mode
  wire hdlc_r = !add_bus_enable_in && mode_in == TABP_MODE_HDLC;
  wire clr_r  = !add_bus_enable_in && mode_in == TABP_MODE_CLEAR;
  wire map_r  = !add_bus_enable_in && mode_in == TABP_MODE_MAPPER;
  a_add_pins_in: assert property (add_bus_enable_in |-> shared_pin_oe_n_out == 3'h7)
    else $error("add role drives pins");
  a_clear_pins_out: assert property (clr_r |-> shared_pin_oe_n_out[2:1] == 2'h0)
    else $error("clear role flags not driven");
  a_slow_dir: assert property (map_r |-> shared_pin_oe_n_out[0] == slow_port_is_input_in)
    else $error("slow clock direction wrong");
  a_slow_clk_rate: assert property (!shared_pin_oe_n_out[0] [*3]
    |-> shared_pin_out[0] != $past(shared_pin_out[0]))
    else $error("slow clock half period wrong");
  a_hdlc_clk_idle: assert property (!hdlc_r [*2] |-> !hdlc_tx_byte_clock_out)
    else $error("byte clock outside role");
  a_hdlc_clk_phase: assert property (disable iff (!arst_n_in || !hdlc_r)
    $rose(hdlc_tx_byte_clock_out) |-> hdlc_tx_byte_clock_out [*4] ##1 !hdlc_tx_byte_clock_out)
    else $error("byte clock phase wrong");
  a_add_role_only: assert property (!add_bus_enable_in [*8] |-> !add_byte_valid_out)
    else $error("add byte outside role");
  a_hdlc_role_only: assert property (!hdlc_r [*8] |-> !hdlc_byte_valid_out)
    else $error("hdlc byte outside role");
  a_pay_role_only: assert property (!clr_r [*8] |-> !payload_valid_out)
    else $error("payload bit outside role");
  // Main scenarios reached
  c_add: cover property (add_byte_valid_out);
  c_pay: cover property (payload_valid_out);
  c_frame: cover property (clr_r && $rose(shared_pin_out[2]));
endmodule

bind tabp_top tabp_sva #(.FRAME_BITS(FRAME_BITS), .OH_SPACING(OH_SPACING)) u_sva (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .add_bus_enable_in(add_bus_enable_in),
  .mode_in(mode_in), .slow_port_is_input_in(slow_port_is_input_in),
  .shared_pin_out(shared_pin_out), .shared_pin_oe_n_out(shared_pin_oe_n_out),
  .hdlc_tx_byte_clock_out(hdlc_tx_byte_clock_out), .add_byte_valid_out(add_byte_valid_out),
  .hdlc_byte_valid_out(hdlc_byte_valid_out), .payload_valid_out(payload_valid_out));

// *** verification/tb_top.sv ***
// Bench for the shared pins: one or more phases per role, random bus data.
// Assumes the far-end model feeds the payload pins.
module tb_top
  import tabp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FRAME_LEN = 16'h0010;
  logic clk_in, arst_n_in, add_bus_enable_in, slow_port_is_input_in, lclk, pclk_q;
  tabp_mode_t mode_in;
  tabp_sig_t slow_sig_type_in;
  logic [7:0] bus_other_in, add_byte_out, hdlc_byte_out;
  logic add_bus_clock_in, hdlc_tx_byte_clock_out, payload_serial_in, payload_input_clock_in;
  logic drop_bit_in, slow_data_out, add_byte_valid_out, hdlc_byte_valid_out;
  logic slow_add_bit_out, slow_add_valid_out, payload_bit_out, payload_valid_out;
  logic [2:0] shared_pin_in, shared_pin_out, shared_pin_oe_n_out, tsh, tbp;
  logic [31:0] seed, rnd;
  int n_mismatch, compares, nv, np, ph, nrise, drv_n;
  // Wire level: the design wins where its enable is low
  assign tbp = (!add_bus_enable_in && mode_in == TABP_MODE_MAPPER && slow_port_is_input_in)
    ? {tsh[2:1], lclk} : tsh;
  assign shared_pin_in = (shared_pin_oe_n_out & tbp) | (~shared_pin_oe_n_out & shared_pin_out);
  assign add_bus_clock_in = lclk & add_bus_enable_in;
  tabp_top #(.FRAME_BITS(FRAME_LEN), .OH_SPACING(8'h04)) DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .add_bus_enable_in(add_bus_enable_in),
    .mode_in(mode_in), .slow_port_is_input_in(slow_port_is_input_in),
    .slow_sig_type_in(slow_sig_type_in), .bus_other_in(bus_other_in),
    .add_bus_clock_in(add_bus_clock_in), .shared_pin_in(shared_pin_in),
    .shared_pin_out(shared_pin_out), .shared_pin_oe_n_out(shared_pin_oe_n_out),
    .hdlc_tx_byte_clock_out(hdlc_tx_byte_clock_out), .payload_serial_in(payload_serial_in),
    .payload_input_clock_in(payload_input_clock_in), .drop_bit_in(drop_bit_in),
    .slow_data_out(slow_data_out), .add_byte_out(add_byte_out),
    .add_byte_valid_out(add_byte_valid_out), .hdlc_byte_out(hdlc_byte_out),
    .hdlc_byte_valid_out(hdlc_byte_valid_out), .slow_add_bit_out(slow_add_bit_out),
    .slow_add_valid_out(slow_add_valid_out), .payload_bit_out(payload_bit_out),
    .payload_valid_out(payload_valid_out));
  tabp_far_end u_far (.clk_in(clk_in),
    .en_in(!add_bus_enable_in && mode_in == TABP_MODE_CLEAR), .oh_in(shared_pin_in[1]),
    .pclk_out(payload_input_clock_in), .pdat_out(payload_serial_in));
  function automatic logic [7:0] expb(logic [7:0] o, logic [2:0] s);
    return {o[7:6], s, o[2:0]};
  endfunction
  function automatic logic pbit(int n);
    return ^(n & 32'h0000_005b);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One role for n cycles; v asks that captures were seen
  task automatic run(input logic e, input tabp_mode_t m, input logic s, input int n, input bit v);
    int n0;
    add_bus_enable_in = e;
    mode_in = m;
    slow_port_is_input_in = s;
    n0 = nv;
    repeat (n) @(negedge clk_in);
    if (v) chk(8'(nv != n0), 8'h01);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Link clock of 160 ns, data changes and capture checks on the quiet edge
  always @(negedge clk_in) begin
    rnd = $random(seed);
    ph <= (ph == 19) ? 0 : ph + 1;
    lclk <= (ph < 10);
    nv = nv + add_byte_valid_out + hdlc_byte_valid_out + slow_add_valid_out + payload_valid_out;
    if (add_byte_valid_out === 1'b1) chk(add_byte_out, expb(bus_other_in, tsh));
    if (hdlc_byte_valid_out === 1'b1) chk(hdlc_byte_out, expb(bus_other_in, tsh));
    if (slow_add_valid_out === 1'b1) chk(8'(slow_add_bit_out), 8'(bus_other_in[0]));
    if (payload_valid_out === 1'b1) chk(8'(payload_bit_out), 8'(pbit(np)));
    if (payload_valid_out === 1'b1) np++;
    // Boundary read at each payload clock rise, before the design moves on
    if (arst_n_in && !add_bus_enable_in && mode_in == TABP_MODE_CLEAR
        && payload_input_clock_in && !pclk_q) begin
      chk(8'(shared_pin_out[2]), 8'((nrise % FRAME_LEN) == 0));
      nrise++;
    end
    pclk_q = payload_input_clock_in;
    // Drop data follows the falling slow clock; first cycles of a run skipped
    drv_n = shared_pin_oe_n_out[0] ? 0 : drv_n + 1;
    if (drv_n >= 2 && !shared_pin_out[0]) chk(8'(slow_data_out), 8'(drop_bit_in));
    // Bytes change only away from any capture edge
    if ((ph == 9 && (add_bus_enable_in || mode_in != TABP_MODE_HDLC))
        || hdlc_byte_valid_out === 1'b1) begin
      bus_other_in <= rnd[7:0];
      tsh <= rnd[10:8];
      drop_bit_in <= rnd[11];
    end
  end
  initial begin
    {n_mismatch, compares, nv, np, ph, nrise, drv_n} = '0;
    seed = 32'ha8cc;
    {arst_n_in, add_bus_enable_in, slow_port_is_input_in, lclk, drop_bit_in, pclk_q} = '0;
    {bus_other_in, tsh} = '0;
    mode_in = TABP_MODE_OTHER;
    slow_sig_type_in = TABP_SIG_E3;
    repeat (3) @(negedge clk_in);
    chk({5'h00, shared_pin_oe_n_out}, 8'h07);
    chk({5'h00, add_byte_valid_out, hdlc_tx_byte_clock_out, payload_valid_out}, 8'h00);
    arst_n_in = 1'b1;
    run(1'b1, TABP_MODE_CLEAR, 1'b0, 600, 1'b1);
    run(1'b0, TABP_MODE_HDLC, 1'b0, 400, 1'b1);
    run(1'b0, TABP_MODE_MAPPER, 1'b1, 600, 1'b1);
    for (int i = 0; i < 3; i++) begin
      slow_sig_type_in = tabp_sig_t'(i);
      run(1'b0, TABP_MODE_MAPPER, 1'b0, 100, 1'b0);
    end
    run(1'b0, TABP_MODE_CLEAR, 1'b0, 2000, 1'b1);
    arst_n_in = 1'b0;
    @(negedge clk_in);
    // Pin enables follow the role alone, so clear mode still drives here
    chk({5'h00, shared_pin_oe_n_out}, 8'h01);
    chk({5'h00, add_byte_valid_out, hdlc_tx_byte_clock_out, payload_valid_out}, 8'h00);
    arst_n_in = 1'b1;
    run(1'b0, TABP_MODE_OTHER, 1'b0, 200, 1'b0);
    run(1'b1, TABP_MODE_HDLC, 1'b0, 300, 1'b1);
    stop_test();
  end
  // Watchdog well beyond the 4,400 cycles of the phases
  initial begin
    #60us;
    n_mismatch++;
    stop_test();
  end
endmodule
